// ---- rtl/fcs_config_bank.sv ----
// Configuration bank for drive strength, protection scheme and power-down depth.
//
// Functional notes
// - Drive field two bits, resets to 01
// - Scheme 0 protects by region fields
// - Scheme 1 protects by per-block lock bits
// - All block locks set after any reset
// - Commands 36h lock, 39h unlock block
// - Depth 0: B9h acts as 79h, ultra-deep
// - Depth 1: B9h enters ordinary deep power-down
// - Only ABh wakes from either power-down
// - Chip select toggling alone never wakes
// - Bit 7 picks hold or reset pin while quad_enable is low
`timescale 1ns/1ps
module fcs_config_bank
	import fcs_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Avalon-MM slave.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Decoded command from the serial front end.
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [3:0] cmd_block,
	input wire logic cs_toggle,
	// Status from elsewhere in the device.
	input wire logic quad_enable,
	input wire logic region_hit,
	input wire logic [3:0] access_block,
	// Control outputs.
	output logic [1:0] drive_strength_sel,
	output logic pin_is_reset,
	output logic pin_is_hold,
	output logic access_protected,
	output logic deep_sleep,
	output logic ultra_deep_sleep,
	output logic sram_retain
);

	////////////////////////////////////////////////////////////////////////////////
	// Register state.
	// Every field here is volatile and returns to its default on any reset.

	// Drive field, scheme select and pin function bit.
	logic [1:0] drv, next_drv;
	logic protect_scheme_sel, next_wps;
	logic hold_reset, next_hold_reset;
	// Power-down depth select.
	logic powerdown_depth_sel, next_pdm;
	// One lock bit per block.
	logic [NUM_BLOCKS-1:0] locks, next_locks;
	// Power state.
	fcs_pwr_t pwr, next_pwr;
	// Bus answer registers; the slave answers one cycle after the request.
	logic ack, next_ack;
	logic [31:0] rdata, next_rdata;
	// Next waitrequest value; the pin comes straight from a flop, never from a gate.
	logic next_wait;
	// Output registers.
	logic [1:0] next_drive_out;
	logic next_pin_reset, next_pin_hold, next_prot;
	logic next_deep, next_ultra, next_retain;

	// Request seen this cycle and not yet answered.
	logic req;
	// Command taken as if written over the bus or arriving from the front end.
	logic cmd_go;
	logic [7:0] cmd_c;
	logic [3:0] cmd_b;

	// Builds the read word of a register.
	function automatic logic [31:0] read_word(input logic [3:0] a);
		logic [31:0] w;
		w = 32'h0;
		// Bits not set below stay zero, which covers every reserved position.
		if (a == ADDR_DRIVE_PROTECT) begin
			w[HOLD_RESET_BIT] = hold_reset;
			w[DRV_LSB+:2] = drv;
			w[WPS_BIT] = protect_scheme_sel;
		end else if (a == ADDR_POWER_PROGRAM) begin
			w[PDM_BIT] = powerdown_depth_sel;
		end else if (a == ADDR_BLOCK_LOCKS) begin
			w[NUM_BLOCKS-1:0] = locks;
		end else if (a == ADDR_COMMAND) begin
			w[1:0] = pwr;
		end
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Bus writes land on the cycle the request is acknowledged, so each one lands once.
	always_comb begin
		// A request is taken only while no answer is standing, so a held request
		// is answered once and the master sees exactly one low cycle of waitrequest.
		req = (avs_read | avs_write) & ~ack;
		next_ack = req;
		next_wait = ~req;
		next_rdata = avs_read && req ? read_word(avs_address) : 32'h0;
		next_drv = drv;
		next_wps = protect_scheme_sel;
		next_hold_reset = hold_reset;
		next_pdm = powerdown_depth_sel;
		next_locks = locks;
		next_pwr = pwr;
		cmd_go = cmd_valid;
		cmd_c = cmd_code;
		cmd_b = cmd_block;
		// Registers are only writable while awake; a sleeping device ignores all writes but those to the command port.
		if (avs_write && ack && pwr == PWR_ACTIVE) begin
			if (avs_address == ADDR_DRIVE_PROTECT) begin
				// The reserved code 00 is refused so the driver is never left off.
				if (avs_writedata[DRV_LSB+:2] != DRV_RESERVED) begin
					next_drv = avs_writedata[DRV_LSB+:2];
				end
				// Scheme select and pin function bit take the written value as is.
				next_wps = avs_writedata[WPS_BIT];
				next_hold_reset = avs_writedata[HOLD_RESET_BIT];
			end else if (avs_address == ADDR_POWER_PROGRAM) begin
				// Only the depth bit of the power register is writable here.
				next_pdm = avs_writedata[PDM_BIT];
			end
		end
		// A command written on the bus takes the place of the front end's.
		// The command port stays open while asleep, since that is the only way
		// software can wake the bank without the serial front end.
		if (avs_write && ack && avs_address == ADDR_COMMAND) begin
			cmd_go = 1'b1;
			cmd_c = avs_writedata[7:0];
			cmd_b = avs_writedata[CMD_BLOCK_LSB+:4];
		end
		// Power state handling; cs_toggle is deliberately not consulted.
		// A sleeping device must not treat a bare chip-select pulse as a wake, so
		// only a decoded wake command moves the state back to active.
		case (pwr)
			// Awake: sleep commands first, then the block lock commands.
			PWR_ACTIVE: begin
				if (cmd_go && cmd_c == CMD_ULTRA_PD) begin
					next_pwr = PWR_ULTRA;
				end else if (cmd_go && cmd_c == CMD_DEEP_PD) begin
					next_pwr = powerdown_depth_sel ? PWR_DEEP : PWR_ULTRA;
				end else if (cmd_go && protect_scheme_sel && cmd_c == CMD_BLOCK_LOCK) begin
					next_locks[cmd_b] = 1'b1;
				end else if (cmd_go && protect_scheme_sel && cmd_c == CMD_BLOCK_UNLOCK) begin
					next_locks[cmd_b] = 1'b0;
				end
			end
			// Either depth of power-down leaves only on the wake command.
			PWR_DEEP, PWR_ULTRA: begin
				if (cmd_go && cmd_c == CMD_WAKE) begin
					next_pwr = PWR_ACTIVE;
				end
			end
			// The unused code falls back to active rather than locking up.
			default: begin
				next_pwr = PWR_ACTIVE;
			end
		endcase
		// Output values. They are taken from the next state so that each output flop
		// changes on the same edge as the field behind it, at the cost of a longer
		// path from the bus inputs to the output flops.
		next_drive_out = next_drv;
		next_pin_reset = next_hold_reset & ~quad_enable;
		next_pin_hold = ~next_hold_reset & ~quad_enable;
		// With the scheme bit set the region verdict is ignored entirely.
		next_prot = next_wps ? next_locks[access_block] : region_hit;
		next_deep = next_pwr == PWR_DEEP;
		next_ultra = next_pwr == PWR_ULTRA;
		next_retain = next_pwr != PWR_ULTRA;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	// Every reset puts the fields back to their defaults and locks all blocks.
	// A mid-run reset is treated exactly like the power-on one.
	always_ff @(posedge mclk) begin
		if (srst) begin
			drv <= DRV_RESET;
			protect_scheme_sel <= WPS_RESET;
			hold_reset <= PIN_FN_RESET;
			powerdown_depth_sel <= PDM_RESET;
			locks <= LOCKS_RESET;
			pwr <= PWR_ACTIVE;
			ack <= 1'b0;
			// The bus is held off for as long as reset stands.
			avs_waitrequest <= 1'b1;
			rdata <= 32'h0;
			drive_strength_sel <= DRV_RESET;
			pin_is_reset <= 1'b0;
			pin_is_hold <= 1'b0;
			access_protected <= 1'b0;
			deep_sleep <= 1'b0;
			ultra_deep_sleep <= 1'b0;
			sram_retain <= 1'b1;
		end else begin
			drv <= next_drv;
			protect_scheme_sel <= next_wps;
			hold_reset <= next_hold_reset;
			powerdown_depth_sel <= next_pdm;
			locks <= next_locks;
			pwr <= next_pwr;
			ack <= next_ack;
			avs_waitrequest <= next_wait;
			rdata <= next_rdata;
			drive_strength_sel <= next_drive_out;
			pin_is_reset <= next_pin_reset;
			pin_is_hold <= next_pin_hold;
			access_protected <= next_prot;
			deep_sleep <= next_deep;
			ultra_deep_sleep <= next_ultra;
			sram_retain <= next_retain;
		end
	end

	// Waitrequest is low only in the acknowledge cycle, when it mirrors ack.
	// Read data is zero outside that cycle, so a late sample shows a plain zero.
	assign avs_readdata = rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.
	// Each property watches what the bank drives; past inputs also appear in some consequents.

	// A front-end deep power-down command while awake.
	sequence s_deep_cmd;
		pwr == PWR_ACTIVE && cmd_valid && !(avs_write && ack && avs_address == ADDR_COMMAND)
			&& cmd_code == CMD_DEEP_PD;
	endsequence

	// A wake command from the front end while powered down.
	sequence s_wake_cmd;
		pwr != PWR_ACTIVE && cmd_valid && !(avs_write && ack && avs_address == ADDR_COMMAND)
			&& cmd_code == CMD_WAKE;
	endsequence

	// A front-end lock or unlock command while awake.
	sequence s_lock_any;
		pwr == PWR_ACTIVE && cmd_valid && !(avs_write && ack)
			&& (cmd_code == CMD_BLOCK_LOCK || cmd_code == CMD_BLOCK_UNLOCK);
	endsequence

	a_drive_not_reserved: assert property (@(posedge mclk) disable iff (srst)
		drive_strength_sel != DRV_RESERVED) else $error("drive field took reserved code");

	a_locks_after_reset: assert property (@(posedge mclk)
		$fell(srst) |-> locks == LOCKS_RESET) else $error("locks not all set after reset");

	a_ultra_on_depth0: assert property (@(posedge mclk) disable iff (srst)
		s_deep_cmd and (powerdown_depth_sel == 1'b0) |=> pwr == PWR_ULTRA ##1 ultra_deep_sleep && !sram_retain)
		else $error("B9h with depth 0 did not enter ultra-deep");

	a_deep_on_depth1: assert property (@(posedge mclk) disable iff (srst)
		s_deep_cmd and (powerdown_depth_sel == 1'b1) |=> pwr == PWR_DEEP ##1 deep_sleep && sram_retain)
		else $error("B9h with depth 1 did not enter deep");

	a_wake_only_abh: assert property (@(posedge mclk) disable iff (srst)
		pwr != PWR_ACTIVE && !(cmd_valid && cmd_code == CMD_WAKE)
			&& !(avs_write && ack && avs_address == ADDR_COMMAND) |=> pwr != PWR_ACTIVE)
		else $error("woke without ABh");

	a_cs_no_wake: assert property (@(posedge mclk) disable iff (srst)
		pwr != PWR_ACTIVE && cs_toggle && !cmd_valid && !(avs_write && ack) |=> $stable(pwr))
		else $error("chip select toggle changed power state");

	a_lock_cmd: assert property (@(posedge mclk) disable iff (srst)
		pwr == PWR_ACTIVE && protect_scheme_sel && cmd_valid && !(avs_write && ack)
			&& cmd_code == CMD_BLOCK_UNLOCK |=> !locks[$past(cmd_block)])
		else $error("unlock command did not clear lock");

	a_scheme_prot: assert property (@(posedge mclk) disable iff (srst)
		protect_scheme_sel && !$past(srst) |-> access_protected == locks[$past(access_block)])
		else $error("per-block protection wrong");

	a_region_prot: assert property (@(posedge mclk) disable iff (srst)
		!protect_scheme_sel && !$past(srst) |-> access_protected == $past(region_hit))
		else $error("region protection wrong");

	a_pin_function: assert property (@(posedge mclk) disable iff (srst)
		quad_enable |=> !pin_is_reset && !pin_is_hold) else $error("pin function with quad set");

	a_reserved_zero: assert property (@(posedge mclk) disable iff (srst)
		ack |-> avs_readdata[31:16] == 16'h0) else $error("reserved bits not zero");

	a_wake_on_abh: assert property (@(posedge mclk) disable iff (srst)
		s_wake_cmd |=> pwr == PWR_ACTIVE && !deep_sleep && !ultra_deep_sleep && sram_retain)
		else $error("wake command did not wake");

	a_lock_set: assert property (@(posedge mclk) disable iff (srst)
		s_lock_any and (protect_scheme_sel && cmd_code == CMD_BLOCK_LOCK) |=> locks[$past(cmd_block)])
		else $error("lock command did not set lock");

	a_lock_ignored: assert property (@(posedge mclk) disable iff (srst)
		s_lock_any and (!protect_scheme_sel) |=> $stable(locks))
		else $error("lock command acted with region scheme");

	a_cfg_reserved: assert property (@(posedge mclk) disable iff (srst)
		avs_read && !avs_waitrequest && avs_address == ADDR_DRIVE_PROTECT
			|-> avs_readdata[4:3] == 2'h0 && avs_readdata[1:0] == 2'h0)
		else $error("reserved config bits not zero");

	a_reset_defaults: assert property (@(posedge mclk)
		srst |=> drive_strength_sel == DRV_RESET && locks == LOCKS_RESET && !deep_sleep)
		else $error("reset values not restored");

endmodule

// ---- rtl/fcs_pkg.sv ----
// Package of offsets, field positions, reset values and commands for the flash config bank.
package fcs_pkg;
	// Register word byte addresses on the Avalon-MM slave.
	localparam logic [3:0] ADDR_DRIVE_PROTECT = 4'h0;
	localparam logic [3:0] ADDR_POWER_PROGRAM = 4'h4;
	localparam logic [3:0] ADDR_BLOCK_LOCKS = 4'h8;
	localparam logic [3:0] ADDR_COMMAND = 4'hC;
	// Field positions in the drive and protect register.
	localparam int HOLD_RESET_BIT = 7;
	localparam int DRV_LSB = 5;
	localparam int WPS_BIT = 2;
	// Field positions in the power and program register.
	localparam int PDM_BIT = 7;
	// Field positions in the command word.
	localparam int CMD_BLOCK_LSB = 8;
	// Reset values.
	localparam logic [1:0] DRV_RESET = 2'h1;
	localparam logic [1:0] DRV_RESERVED = 2'h0;
	localparam logic [15:0] LOCKS_RESET = 16'hFFFF;
	localparam logic WPS_RESET = 1'h0;
	localparam logic PIN_FN_RESET = 1'h0;
	localparam logic PDM_RESET = 1'h0;
	// Number of lockable blocks.
	localparam int NUM_BLOCKS = 16;
	// Commands.
	localparam logic [7:0] CMD_BLOCK_LOCK = 8'h36;
	localparam logic [7:0] CMD_BLOCK_UNLOCK = 8'h39;
	localparam logic [7:0] CMD_DEEP_PD = 8'hB9;
	localparam logic [7:0] CMD_ULTRA_PD = 8'h79;
	localparam logic [7:0] CMD_WAKE = 8'hAB;
	// Power states.
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_DEEP = 2'b01,
		PWR_ULTRA = 2'b10
	} fcs_pwr_t;
endpackage

// ---- sim/fcs_host_model.sv ----
// SPI host model that hands decoded commands to the config bank.
`timescale 1ns/1ps
module fcs_host_model (
	// Clock.
	input wire logic mclk,
	// Decoded command lines.
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic [3:0] cmd_block,
	output logic cs_toggle
);
	// Lines start idle so the bank sees no command at power-up.
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_block = 4'h0;
		cs_toggle = 1'b0;
	end
	// One command pulse; released lines are inverted so stale codes never look valid.
	task automatic send(input logic [7:0] code, input logic [3:0] blk);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_block <= blk;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		cmd_code <= ~code;
		cmd_block <= ~blk;
		repeat (3) @(posedge mclk);
	endtask
	// Chip select pulse with no command behind it.
	task automatic toggle();
		@(posedge mclk);
		cs_toggle <= 1'b1;
		@(posedge mclk);
		cs_toggle <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the flash config bank.
`timescale 1ns/1ps
`define CHK(n,e,g) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
	import fcs_pkg::*;
	// Bench drives, all idle at time zero except srst, which starts asserted.
	logic mclk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0, access_block = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
	logic quad_enable = 1'b0, region_hit = 1'b0, avs_waitrequest;
	logic cmd_valid, cs_toggle, pin_is_reset, pin_is_hold, access_protected;
	logic deep_sleep, ultra_deep_sleep, sram_retain;
	logic [7:0] cmd_code;
	logic [3:0] cmd_block;
	logic [1:0] drive_strength_sel;
	int fail_count = 0, tests_run = 0;
	always #20 mclk = ~mclk;
	fcs_config_bank i_dut (.mclk(mclk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_block(cmd_block),
		.cs_toggle(cs_toggle), .quad_enable(quad_enable), .region_hit(region_hit),
		.access_block(access_block), .drive_strength_sel(drive_strength_sel),
		.pin_is_reset(pin_is_reset), .pin_is_hold(pin_is_hold),
		.access_protected(access_protected), .deep_sleep(deep_sleep),
		.ultra_deep_sleep(ultra_deep_sleep), .sram_retain(sram_retain));
	fcs_host_model i_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_block(cmd_block), .cs_toggle(cs_toggle));
	////////////////////////////////////////////////////////////////
	// One Avalon cycle; the request holds until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// Read a register and compare it.
	task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		`CHK(n, e, rdata)
	endtask
	////////////////////////////////////////////////////////////////
	// Reset values and the drive field, reserved bits and pin function.
	task automatic t_drive();
		rchk(ADDR_DRIVE_PROTECT, {24'h0, 1'b0, DRV_RESET, 5'h0}, "cfg0");
		rchk(ADDR_BLOCK_LOCKS, {16'h0, LOCKS_RESET}, "locks");
		`CHK("hold", 1'b1, pin_is_hold)
		bus(1'b1, ADDR_DRIVE_PROTECT, 32'hFFFFFFFF);
		rchk(ADDR_DRIVE_PROTECT, 32'hE4, "cfg0 ones");
		bus(1'b1, ADDR_POWER_PROGRAM, 32'hFFFFFFFF);
		rchk(ADDR_POWER_PROGRAM, 32'h80, "cfg4 ones");
		`CHK("reset pin", 1'b1, pin_is_reset)
		quad_enable <= 1'b1;
		repeat (3) @(posedge mclk);
		`CHK("pin off", 2'b00, {pin_is_reset, pin_is_hold})
		quad_enable <= 1'b0;
		// Code 00 is refused while the neighbouring bits still land.
		bus(1'b1, ADDR_DRIVE_PROTECT, 32'h04);
		rchk(ADDR_DRIVE_PROTECT, 32'h64, "drv00");
		for (int d = 1; d < 4; d++) begin
			bus(1'b1, ADDR_DRIVE_PROTECT, {25'h0, d[1:0], 5'h0});
			repeat (2) @(posedge mclk);
			`CHK("drive", d[1:0], drive_strength_sel)
		end
		bus(1'b1, ADDR_POWER_PROGRAM, 32'h0);
		rchk(4'h2, 32'h0, "unmapped");
		$display("test drive done");
	endtask
	// Region versus per-block protection, lock commands and reset of locks.
	task automatic t_protect();
		region_hit <= 1'b1;
		access_block <= 4'h3;
		repeat (3) @(posedge mclk);
		`CHK("region", 1'b1, access_protected)
		i_host.send(CMD_BLOCK_UNLOCK, 4'h3);
		rchk(ADDR_BLOCK_LOCKS, 32'hFFFF, "lock wps0");
		bus(1'b1, ADDR_DRIVE_PROTECT, 32'h24);
		i_host.send(CMD_BLOCK_UNLOCK, 4'h3);
		rchk(ADDR_BLOCK_LOCKS, 32'hFFF7, "unlock3");
		`CHK("blk open", 1'b0, access_protected)
		bus(1'b1, ADDR_COMMAND, {20'h0, 4'h3, CMD_BLOCK_LOCK});
		rchk(ADDR_BLOCK_LOCKS, 32'hFFFF, "lock3");
		`CHK("blk shut", 1'b1, access_protected)
		i_host.send(CMD_BLOCK_UNLOCK, 4'hF);
		rchk(ADDR_BLOCK_LOCKS, 32'h7FFF, "unlock15");
		i_host.send(CMD_BLOCK_LOCK, 4'hF);
		i_host.send(CMD_BLOCK_UNLOCK, 4'h0);
		rchk(ADDR_BLOCK_LOCKS, 32'hFFFE, "lock15");
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		rchk(ADDR_BLOCK_LOCKS, 32'hFFFF, "relock");
		region_hit <= 1'b0;
		$display("test protect done");
	endtask
	// Power-down depth, chip select toggles and the wake command.
	task automatic t_power();
		for (int p = 0; p < 2; p++) begin
			bus(1'b1, ADDR_POWER_PROGRAM, {24'h0, p[0], 7'h0});
			i_host.send(CMD_DEEP_PD, 4'h0);
			`CHK("sleep", {!p[0], p[0], p[0]}, {ultra_deep_sleep, deep_sleep, sram_retain})
			i_host.toggle();
			rchk(ADDR_COMMAND, p[0] ? 32'h1 : 32'h2, "asleep");
			bus(1'b1, ADDR_DRIVE_PROTECT, 32'hE0);
			rchk(ADDR_DRIVE_PROTECT, 32'h20, "frozen");
			i_host.send(CMD_WAKE, 4'h0);
			rchk(ADDR_COMMAND, 32'h0, "awake");
		end
		i_host.send(CMD_ULTRA_PD, 4'h0);
		`CHK("ultra", 1'b1, ultra_deep_sleep)
		i_host.send(CMD_WAKE, 4'h0);
		$display("test power done");
	endtask
	////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence after a 16-cycle reset.
	initial begin
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		t_drive();
		t_protect();
		t_power();
		end_sim();
	end
	// Watchdog, far beyond the few hundred cycles the tests need.
	initial begin
		#200000;
		fail_count++;
		end_sim();
	end
endmodule
